// ==== verilog/ptw_regs.svh ====
// Constants of the periodic timer and watchdog unit
//
// Overview of operation
// - All counting except on alternate clock derives from 32.768 kHz input
// - Prescaler divides by two to the exponent
// - Timer is 16-bit down-counter on tick
// - Reload preset after zero, period preset plus one
// - Tick output high one prescaled tick
// - Tick output goes to interrupt controller
// - New preset used only at next reload
// - Restart bit forces reload on next tick
// - Hardware clears restart bit after reload
// - Watchdog is 8-bit down-counter on source
// - Watchdog idle after reset until started
// - Count or match write starts; only reset stops
// - Unlocked count write loads and counts down
// - Key write reloads from stored count
// - Wrong match data fires watchdog at once
// - Counter reaching zero fires watchdog
// - Two services in one clock fire watchdog
// - Select zero timer tick, one prescaled tick
// - Hardware select overrides with alternate clock
// - Lock bits stick until reset
// - Timer lock blocks preset and control writes
// - Match writes ignored while match disabled
// - Watchdog count resets to 0Fh
// - Timer preset resets to FFFFh
`ifndef PTW_REGS_SVH
`define PTW_REGS_SVH

// ----------------------------------------------------------------------
// Configuration bit positions
// ----------------------------------------------------------------------
`define PTW_CFG_LOCK_CFG 0
`define PTW_CFG_LOCK_PRESC 1
`define PTW_CFG_LOCK_TIMER 2
`define PTW_CFG_LOCK_COUNT 3
`define PTW_CFG_WD_CLK_SEL 4
`define PTW_CFG_MATCH_EN 5
`define PTW_TCSR_RESTART 0

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define PTW_LOCKS_RST 4'h0
`define PTW_PRESCALE_EXPONENT_RST 3'h0
`define PTW_PRESCALE_EXPONENT_MAX 3'h5
`define PTW_PRESET_RST 16'hffff
`define PTW_WATCHDOG_COUNT_REGISTER_RST 8'h0f
`define PTW_SERVICE_KEY 8'h5c

`endif

// ==== verilog/ptw_pkg.sv ====
// Types shared by the periodic timer and watchdog modules
package ptw_pkg;

  typedef enum logic [2:0] {
    PTW_WD_IDLE  = 3'b001,
    PTW_WD_RUN   = 3'b010,
    PTW_WD_FIRED = 3'b100
  } ptw_wd_state_t;

endpackage

// ==== verilog/ptw_tick_if.sv ====
// Link between the prescaler and the timer core
`timescale 1ns/1ns
interface ptw_tick_if;
  logic [2:0] prescale_exponent;
  logic prescaled_tick;

  modport src (
    input prescale_exponent,
    output prescaled_tick
  );

  modport sink (
    output prescale_exponent,
    input prescaled_tick
  );
endinterface

// ==== verilog/ptw_prescaler.sv ====
// Power-of-two prescaler of the low-frequency clock
`timescale 1ns/1ns
`include "ptw_regs.svh"
module ptw_prescaler
  import ptw_pkg::*;
#(
  parameter int DIV_W = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic lf_clk_in,
  ptw_tick_if.src tick_bus
);

  logic lf_prev_ff;
  logic nxt_lf_prev;
  logic [DIV_W-1:0] div_cnt_ff;
  logic [DIV_W-1:0] nxt_div_cnt;
  logic tick_ff;
  logic nxt_tick;
  logic [DIV_W-1:0] mask;
  logic lf_rise;
  logic [2:0] exp_eff;

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  always_comb begin
    // Reserved exponents behave as the largest legal ratio
    exp_eff = (tick_bus.prescale_exponent > `PTW_PRESCALE_EXPONENT_MAX) ? `PTW_PRESCALE_EXPONENT_MAX :
              tick_bus.prescale_exponent;
    mask = DIV_W'((1 << exp_eff) - 1);
    lf_rise = lf_clk_in & ~lf_prev_ff;
    nxt_lf_prev = lf_clk_in;
    nxt_div_cnt = div_cnt_ff;
    nxt_tick = 1'b0;
    if (lf_rise) begin
      nxt_div_cnt = div_cnt_ff + 1'b1;
      nxt_tick = ((div_cnt_ff & mask) == mask);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lf_prev_ff <= 1'b0;
      div_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      lf_prev_ff <= nxt_lf_prev;
      div_cnt_ff <= nxt_div_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_bus.prescaled_tick = tick_ff;

endmodule

// ==== verilog/ptw_top.sv ====
// Periodic timer and watchdog unit, top level
`timescale 1ns/1ns
`include "ptw_regs.svh"
module ptw_top
  import ptw_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic lf_clk_in,
  input wire logic alt_clk_in,
  input wire logic alt_clk_sel,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  input wire logic presc_wr,
  input wire logic [7:0] presc_wdata,
  input wire logic preset_wr,
  input wire logic [15:0] preset_wdata,
  input wire logic tcsr_wr,
  input wire logic [7:0] tcsr_wdata,
  input wire logic tcsr_rd,
  input wire logic watchdog_count_register_wr,
  input wire logic [7:0] watchdog_count_register_wdata,
  input wire logic match_wr,
  input wire logic [7:0] match_wdata,
  output logic prescaled_tick,
  output logic timer_tick_output,
  output logic watchdog_signal,
  output logic [3:0] lock_bits,
  output logic watchdog_clock_select,
  output logic match_service_enable,
  output logic [2:0] prescale_exponent,
  output logic [15:0] periodic_timer_preset,
  output logic timer_restart,
  output logic terminal_count,
  output logic [15:0] timer_count,
  output logic [7:0] watchdog_count,
  output logic watchdog_running
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  ptw_tick_if tick_bus ();

  logic [3:0] lock_ff;
  logic [3:0] nxt_lock;
  logic wd_clk_sel_ff;
  logic nxt_wd_clk_sel;
  logic match_en_ff;
  logic nxt_match_en;
  logic [2:0] prescale_exponent_ff;
  logic [2:0] nxt_prescale_exponent;
  logic cfg_wr_ok;

  logic [15:0] preset_ff;
  logic [15:0] nxt_preset;
  logic [15:0] tcount_ff;
  logic [15:0] nxt_tcount;
  logic restart_ff;
  logic nxt_restart;
  logic tc_ff;
  logic nxt_tc;
  logic tick_ff;
  logic nxt_tick;
  logic ptick_ff;
  logic nxt_ptick;
  logic tick_rise;
  logic ptick;

  ptw_wd_state_t wd_state_ff;
  ptw_wd_state_t nxt_wd_state;
  logic [7:0] wd_cnt_ff;
  logic [7:0] nxt_wd_cnt;
  logic [7:0] wd_reload_ff;
  logic [7:0] nxt_wd_reload;
  logic serviced_ff;
  logic nxt_serviced;
  logic wd_sig_ff;
  logic nxt_wd_sig;
  logic wd_run_ff;
  logic nxt_wd_run;
  logic alt_prev_ff;
  logic nxt_alt_prev;
  logic alt_rise;
  logic wd_ev;
  logic watchdog_count_register_ok;
  logic match_ok;
  logic key_ok;
  logic bad_key;
  logic service;
  logic [7:0] load_val;

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  ptw_prescaler #(
    .DIV_W(5)
  ) u_prescaler (
    .clk(clk),
    .reset_n(reset_n),
    .lf_clk_in(lf_clk_in),
    .tick_bus(tick_bus.src)
  );

  assign tick_bus.prescale_exponent = prescale_exponent_ff;
  assign ptick = tick_bus.prescaled_tick;

  // ----------------------------------------------------------------------
  // Configuration and lock bits
  // ----------------------------------------------------------------------
  assign cfg_wr_ok = cfg_wr & ~lock_ff[`PTW_CFG_LOCK_CFG];

  // Writing zero never clears a lock; only reset does
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lock
      assign nxt_lock[gi] = lock_ff[gi] | (cfg_wr_ok & cfg_wdata[gi]);
    end
  endgenerate

  always_comb begin
    nxt_wd_clk_sel = wd_clk_sel_ff;
    nxt_match_en = match_en_ff;
    nxt_prescale_exponent = prescale_exponent_ff;
    if (cfg_wr_ok) begin
      nxt_wd_clk_sel = cfg_wdata[`PTW_CFG_WD_CLK_SEL];
      nxt_match_en = cfg_wdata[`PTW_CFG_MATCH_EN];
    end
    if (presc_wr && !lock_ff[`PTW_CFG_LOCK_PRESC]) begin
      nxt_prescale_exponent = presc_wdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lock_ff <= `PTW_LOCKS_RST;
      wd_clk_sel_ff <= 1'b0;
      match_en_ff <= 1'b0;
      prescale_exponent_ff <= `PTW_PRESCALE_EXPONENT_RST;
    end else begin
      lock_ff <= nxt_lock;
      wd_clk_sel_ff <= nxt_wd_clk_sel;
      match_en_ff <= nxt_match_en;
      prescale_exponent_ff <= nxt_prescale_exponent;
    end
  end

  // ----------------------------------------------------------------------
  // Periodic timer
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_preset = preset_ff;
    nxt_tcount = tcount_ff;
    nxt_restart = restart_ff;
    nxt_tc = tc_ff;
    nxt_tick = tick_ff;
    nxt_ptick = ptick;
    tick_rise = 1'b0;
    if (preset_wr && !lock_ff[`PTW_CFG_LOCK_TIMER]) begin
      // Count in flight keeps going; preset is sampled only on reload
      nxt_preset = preset_wdata;
    end
    if (ptick) begin
      if (restart_ff || (tcount_ff == 16'h0000)) begin
        nxt_tcount = preset_ff;
        nxt_restart = 1'b0;
      end else begin
        nxt_tcount = tcount_ff - 16'h0001;
      end
      // Output holds for the whole tick cycle in which the count is zero
      nxt_tick = (nxt_tcount == 16'h0000);
      tick_rise = nxt_tick & ~tick_ff;
    end
    if (tcsr_rd) begin
      nxt_tc = 1'b0;
    end
    // A new terminal count beats a read in the same cycle
    if (ptick && (nxt_tcount == 16'h0000)) begin
      nxt_tc = 1'b1;
    end
    // Pending restart survives a tick arriving in the write cycle
    if (tcsr_wr && !lock_ff[`PTW_CFG_LOCK_TIMER] && tcsr_wdata[`PTW_TCSR_RESTART]) begin
      nxt_restart = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      preset_ff <= `PTW_PRESET_RST;
      tcount_ff <= `PTW_PRESET_RST;
      restart_ff <= 1'b0;
      tc_ff <= 1'b0;
      tick_ff <= 1'b0;
      ptick_ff <= 1'b0;
    end else begin
      preset_ff <= nxt_preset;
      tcount_ff <= nxt_tcount;
      restart_ff <= nxt_restart;
      tc_ff <= nxt_tc;
      tick_ff <= nxt_tick;
      ptick_ff <= nxt_ptick;
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog clock source
  // ----------------------------------------------------------------------
  assign nxt_alt_prev = alt_clk_in;
  assign alt_rise = alt_clk_in & ~alt_prev_ff;

  always_comb begin
    if (alt_clk_sel) begin
      wd_ev = alt_rise;
    end else if (wd_clk_sel_ff) begin
      wd_ev = ptick;
    end else begin
      wd_ev = tick_rise;
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  assign watchdog_count_register_ok = watchdog_count_register_wr & ~lock_ff[`PTW_CFG_LOCK_COUNT];
  assign match_ok = match_wr & match_en_ff;
  assign key_ok = match_ok & (match_wdata == `PTW_SERVICE_KEY);
  assign bad_key = match_ok & (match_wdata != `PTW_SERVICE_KEY);
  assign service = watchdog_count_register_ok | key_ok;
  assign load_val = watchdog_count_register_ok ? watchdog_count_register_wdata : wd_reload_ff;

  always_comb begin
    nxt_wd_state = wd_state_ff;
    nxt_wd_cnt = wd_cnt_ff;
    nxt_wd_reload = watchdog_count_register_ok ? watchdog_count_register_wdata : wd_reload_ff;
    nxt_serviced = serviced_ff;
    nxt_wd_sig = wd_sig_ff;
    unique case (wd_state_ff)
      PTW_WD_IDLE: begin
        // Does not count until the first start write; wrong match data still fires it
        if (bad_key) begin
          nxt_wd_state = PTW_WD_FIRED;
          nxt_wd_sig = 1'b1;
        end else if (service) begin
          nxt_wd_state = PTW_WD_RUN;
          nxt_wd_cnt = load_val;
          nxt_serviced = 1'b1;
        end
      end
      PTW_WD_RUN: begin
        if (wd_ev) begin
          nxt_serviced = 1'b0;
          nxt_wd_cnt = wd_cnt_ff - 8'h01;
        end
        if (bad_key) begin
          nxt_wd_state = PTW_WD_FIRED;
          nxt_wd_sig = 1'b1;
        end else if (service) begin
          // A clock edge in the same cycle ends the previous window
          if (serviced_ff && !wd_ev) begin
            nxt_wd_state = PTW_WD_FIRED;
            nxt_wd_sig = 1'b1;
          end else begin
            nxt_wd_cnt = load_val;
            nxt_serviced = 1'b1;
          end
        end else if (wd_ev && (wd_cnt_ff <= 8'h01)) begin
          nxt_wd_state = PTW_WD_FIRED;
          nxt_wd_sig = 1'b1;
        end
      end
      PTW_WD_FIRED: begin
        nxt_wd_sig = 1'b1;
      end
      default: begin
        nxt_wd_state = PTW_WD_FIRED;
        nxt_wd_sig = 1'b1;
      end
    endcase
    nxt_wd_run = (nxt_wd_state != PTW_WD_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wd_state_ff <= PTW_WD_IDLE;
      wd_cnt_ff <= `PTW_WATCHDOG_COUNT_REGISTER_RST;
      wd_reload_ff <= `PTW_WATCHDOG_COUNT_REGISTER_RST;
      serviced_ff <= 1'b0;
      wd_sig_ff <= 1'b0;
      wd_run_ff <= 1'b0;
      alt_prev_ff <= 1'b0;
    end else begin
      wd_state_ff <= nxt_wd_state;
      wd_cnt_ff <= nxt_wd_cnt;
      wd_reload_ff <= nxt_wd_reload;
      serviced_ff <= nxt_serviced;
      wd_sig_ff <= nxt_wd_sig;
      wd_run_ff <= nxt_wd_run;
      alt_prev_ff <= nxt_alt_prev;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Status copy of the tick lags the internal one by a cycle
  assign prescaled_tick = ptick_ff;
  assign timer_tick_output = tick_ff;
  assign watchdog_signal = wd_sig_ff;
  assign lock_bits = lock_ff;
  assign watchdog_clock_select = wd_clk_sel_ff;
  assign match_service_enable = match_en_ff;
  assign prescale_exponent = prescale_exponent_ff;
  assign periodic_timer_preset = preset_ff;
  assign timer_restart = restart_ff;
  assign terminal_count = tc_ff;
  assign timer_count = tcount_ff;
  assign watchdog_count = wd_cnt_ff;
  assign watchdog_running = wd_run_ff;

endmodule

// ==== verif/ptw_properties.sv ====
// Concurrent checks on the timer and watchdog top level ports
`timescale 1ns/1ns
module ptw_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic preset_wr,
  input wire logic watchdog_count_register_wr,
  input wire logic [7:0] watchdog_count_register_wdata,
  input wire logic match_wr,
  input wire logic [7:0] match_wdata,
  input wire logic timer_tick_output,
  input wire logic watchdog_signal,
  input wire logic [3:0] lock_bits,
  input wire logic match_service_enable,
  input wire logic [15:0] periodic_timer_preset,
  input wire logic timer_restart,
  input wire logic [15:0] timer_count,
  input wire logic [7:0] watchdog_count,
  input wire logic watchdog_running
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------
  // Multi-step behaviours
  // ------------------------------------------------------------
  sequence s_first_load;
    watchdog_count_register_wr && !lock_bits[3] && !watchdog_running;
  endsequence
  sequence s_restart_done;
    ##[1:200] !timer_restart;
  endsequence

  a_sig_sticky: assert property (watchdog_signal |=> watchdog_signal)
    else $error("watchdog signal dropped");
  a_run_sticky: assert property (watchdog_running |=> watchdog_running)
    else $error("watchdog stopped");
  a_first_load: assert property (s_first_load |=> watchdog_running)
    else $error("count write did not start watchdog");
  a_count_load: assert property (watchdog_count_register_wr && !lock_bits[3] && !watchdog_signal |=>
    watchdog_count == $past(watchdog_count_register_wdata) || watchdog_signal)
    else $error("count write not loaded");
  a_bad_match: assert property (match_wr && match_service_enable &&
    match_wdata != 8'h5c |=> watchdog_signal)
    else $error("wrong service data did not fire");
  a_match_off: assert property (match_wr && !match_service_enable && !watchdog_count_register_wr &&
    !watchdog_running |=> !watchdog_running)
    else $error("disabled match write started watchdog");
  a_lock_kept: assert property (1'b1 |=>
    (lock_bits & $past(lock_bits)) == $past(lock_bits))
    else $error("lock bit cleared");
  a_preset_lock: assert property (preset_wr && lock_bits[2] |=>
    $stable(periodic_timer_preset))
    else $error("locked preset changed");
  a_tick_zero: assert property ($rose(timer_tick_output) |-> timer_count == 16'h0)
    else $error("tick output without zero count");
  a_restart_done: assert property ($rose(timer_restart) |-> s_restart_done)
    else $error("restart never completed");
  a_count_step: assert property ($changed(timer_count) |->
    timer_count == $past(timer_count) - 16'h1 ||
    timer_count == $past(periodic_timer_preset))
    else $error("timer count jumped");
endmodule

bind ptw_top ptw_properties i_ptw_properties (.clk, .reset_n, .preset_wr, .watchdog_count_register_wr,
  .watchdog_count_register_wdata, .match_wr, .match_wdata, .timer_tick_output, .watchdog_signal,
  .lock_bits, .match_service_enable, .periodic_timer_preset, .timer_restart,
  .timer_count, .watchdog_count, .watchdog_running);

// ==== verif/testbench.sv ====
// Directed testbench of the periodic timer and watchdog unit
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module testbench;
  logic clk = 0, reset_n = 0, lf_clk_in = 0, alt_clk_in = 0, alt_clk_sel = 0, alt_en = 0;
  logic cfg_wr = 0, presc_wr = 0, preset_wr = 0, tcsr_wr = 0, tcsr_rd = 0;
  logic watchdog_count_register_wr = 0, match_wr = 0;
  logic [7:0] cfg_wdata = 0, presc_wdata = 0, tcsr_wdata = 0, watchdog_count_register_wdata = 0;
  logic [7:0] match_wdata = 0;
  logic [15:0] preset_wdata = 0;
  logic prescaled_tick, timer_tick_output, watchdog_signal, watchdog_clock_select;
  logic match_service_enable, timer_restart, terminal_count, watchdog_running;
  logic [3:0] lock_bits;
  logic [2:0] prescale_exponent;
  logic [15:0] periodic_timer_preset, timer_count;
  logic [7:0] watchdog_count;
  logic [2:0] div = 0;
  int mismatches = 0, checks = 0, cyc = 0, n, t, e;

  ptw_top i_ptw_top (.clk, .reset_n, .lf_clk_in, .alt_clk_in, .alt_clk_sel, .cfg_wr,
    .cfg_wdata, .presc_wr, .presc_wdata, .preset_wr, .preset_wdata, .tcsr_wr,
    .tcsr_wdata, .tcsr_rd, .watchdog_count_register_wr, .watchdog_count_register_wdata, .match_wr, .match_wdata,
    .prescaled_tick, .timer_tick_output, .watchdog_signal, .lock_bits,
    .watchdog_clock_select, .match_service_enable, .prescale_exponent,
    .periodic_timer_preset, .timer_restart, .terminal_count, .timer_count,
    .watchdog_count, .watchdog_running);

  always #50 clk = ~clk;

  // ------------------------------------------------------------
  // Low-frequency and alternate clocks, sped up to 4 and 8 cycles
  // ------------------------------------------------------------
  always @(posedge clk) begin
    div <= div + 3'h1;
    lf_clk_in <= div[1];
    alt_clk_in <= alt_en & div[2];
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      wrap_up;
    end
  end

  task step(input int k);
    repeat (k) @(posedge clk);
  endtask

  task rst;
    @(posedge clk);
    reset_n <= 1'b0;
    step(12);
    reset_n <= 1'b1;
  endtask

  // One strobe: 0 cfg, 1 prescaler, 2 preset, 3 control, 4 count, 5 match, 6 status read
  task pulse(input int k, input logic [15:0] d);
    @(posedge clk);
    {cfg_wdata, presc_wdata, tcsr_wdata, watchdog_count_register_wdata, match_wdata} <= {5{d[7:0]}};
    preset_wdata <= d;
    case (k)
      0: cfg_wr <= 1'b1;
      1: presc_wr <= 1'b1;
      2: preset_wr <= 1'b1;
      3: tcsr_wr <= 1'b1;
      4: watchdog_count_register_wr <= 1'b1;
      6: tcsr_rd <= 1'b1;
      default: match_wr <= 1'b1;
    endcase
    @(posedge clk);
    {cfg_wr, presc_wr, preset_wr, tcsr_wr, watchdog_count_register_wr, match_wr, tcsr_rd} <= 7'h0;
  endtask

  function logic sig(input bit s);
    return s ? timer_tick_output : prescaled_tick;
  endfunction

  // Cycles from now to the next rising edge of the chosen output
  task rise(input bit s, output int c);
    c = 0;
    while (sig(s) === 1'b1 && c < 999) begin
      @(posedge clk);
      c++;
    end
    while (sig(s) !== 1'b1 && c < 999) begin
      @(posedge clk);
      c++;
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    rst;
    step(20);
    `CHK("preset", 16'hffff, periodic_timer_preset)
    `CHK("wd count", 8'h0f, watchdog_count)
    `CHK("running", 1'b0, watchdog_running)
    `CHK("signal", 1'b0, watchdog_signal)
    $display("test reset done");
    for (e = 0; e < 6; e++) begin
      pulse(1, e);
      rise(0, n);
      rise(0, n);
      `CHK("tick gap", 4 << e, n)
    end
    pulse(1, 0);
    $display("test prescaler done");
    pulse(2, 3);
    pulse(3, 1);
    step(1);
    n = 0;
    while (timer_restart === 1'b1 && n < 999) begin
      @(posedge clk);
      n++;
    end
    `CHK("restart load", 16'h0003, timer_count)
    rise(1, n);
    rise(1, n);
    `CHK("period", 16, n)
    `CHK("tc set", 1'b1, terminal_count)
    pulse(6, 0);
    step(1);
    `CHK("tc read", 1'b0, terminal_count)
    step(2);
    pulse(2, 5);
    rise(1, n);
    `CHK("old period", 16, n + 7)
    rise(1, n);
    `CHK("new period", 24, n)
    $display("test timer done");
    rst;
    pulse(4, 3);
    step(1);
    `CHK("running", 1'b1, watchdog_running)
    `CHK("wd load", 8'h03, watchdog_count)
    pulse(4, 3);
    step(1);
    `CHK("early", 1'b1, watchdog_signal)
    $display("test early count done");
    rst;
    pulse(0, 8'h30);
    // Slower tick so that two back-to-back keys fall inside one watchdog clock
    pulse(1, 2);
    `CHK("match en", 1'b1, match_service_enable)
    `CHK("clk sel", 1'b1, watchdog_clock_select)
    pulse(5, 8'h5c);
    step(1);
    `CHK("key start", 1'b1, watchdog_running)
    `CHK("key load", 8'h0f, watchdog_count)
    rise(0, n);
    pulse(5, 8'h5c);
    step(1);
    `CHK("key reload", 8'h0f, watchdog_count)
    `CHK("on time", 1'b0, watchdog_signal)
    pulse(5, 8'h5c);
    step(1);
    `CHK("early key", 1'b1, watchdog_signal)
    rst;
    pulse(0, 8'h20);
    pulse(5, 8'h11);
    step(1);
    `CHK("bad data", 1'b1, watchdog_signal)
    $display("test match done");
    rst;
    pulse(0, 8'h10);
    pulse(5, 8'h11);
    step(1);
    `CHK("match off", 1'b0, watchdog_running)
    `CHK("match off sig", 1'b0, watchdog_signal)
    alt_clk_sel <= 1'b1;
    pulse(4, 2);
    step(100);
    `CHK("alt held", 1'b0, watchdog_signal)
    alt_en <= 1'b1;
    step(40);
    `CHK("late", 1'b1, watchdog_signal)
    pulse(4, 9);
    step(1);
    `CHK("sticky", 1'b1, watchdog_signal)
    alt_en <= 1'b0;
    alt_clk_sel <= 1'b0;
    $display("test late done");
    rst;
    pulse(0, 8'h0e);
    pulse(0, 8'h00);
    pulse(0, 8'h01);
    pulse(0, 8'h30);
    pulse(2, 7);
    pulse(1, 2);
    pulse(4, 5);
    pulse(3, 1);
    step(1);
    `CHK("locks", 4'hf, lock_bits)
    `CHK("locked cfg", 1'b0, match_service_enable)
    `CHK("locked preset", 16'hffff, periodic_timer_preset)
    `CHK("locked exp", 3'h0, prescale_exponent)
    `CHK("locked count", 1'b0, watchdog_running)
    `CHK("locked restart", 1'b0, timer_restart)
    $display("test locks done");
    wrap_up;
  end
endmodule
